// *** mif_sink_model.sv ***
// downstream sink model for the multibank interpolating fir filter
`include "multibank_interp_fir_cfg.svh"
`timescale 1ns/100ps
`default_nettype none

// ===========================================================================
// sink: takes words promptly, every other cycle when slow, never when stalled
module mif_sink_model (
	input  wire logic                 i_clk,
	input  wire logic                 i_rst_n,
	input  wire logic                 i_stall,
	input  wire logic                 i_slow,
	input  wire logic                 i_valid,
	input  wire logic [`MIF_DW-1:0]   i_data,
	input  wire logic [0:0]           i_bank,
	input  wire logic [1:0]           i_chan,
	input  wire logic [0:0]           i_phase,
	output var  logic                 o_ready,
	output var  logic [15:0]          o_count,
	output var  logic [`MIF_DW-1:0]   o_data,
	output var  logic [0:0]           o_bank,
	output var  logic [1:0]           o_chan,
	output var  logic [0:0]           o_phase
);
	logic tgl_r;
	assign o_ready = ~i_stall & (~i_slow | tgl_r);
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			tgl_r   <= 1'b0;
			o_count <= 16'h0000;
			o_data  <= '0;
			o_bank  <= '0;
			o_chan  <= '0;
			o_phase <= '0;
		end else begin
			tgl_r <= ~tgl_r;
			// a word counts only at the edge where valid and ready meet
			if (i_valid && o_ready) begin
				o_count <= o_count + 16'h0001;
				o_data  <= i_data;
				o_bank  <= i_bank;
				o_chan  <= i_chan;
				o_phase <= i_phase;
			end
		end
	end
endmodule : mif_sink_model

`default_nettype wire

// *** multibank_interp_fir.sv ***
// multibank interpolating fir filter with its input fifo
`include "multibank_interp_fir_cfg.svh"
`timescale 1ns/100ps
`default_nettype none

// ===========================================================================
// input fifo
module mif_fifo #(
	parameter int W     = 18,
	parameter int DEPTH = `MIF_FIFO_DEPTH
) (
	input  wire logic         i_clk,
	input  wire logic         i_rst_n,
	input  wire logic         i_in_valid,
	input  wire logic [W-1:0] i_in_data,
	output var  logic         o_in_ready,
	output var  logic         o_out_valid,
	output var  logic [W-1:0] o_out_data,
	input  wire logic         i_out_ready
);
	localparam int PW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);
	logic [W-1:0]  mem_r   [DEPTH];
	logic [W-1:0]  mem_nxt [DEPTH];
	logic [PW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
	logic [CW-1:0] cnt_r, cnt_nxt;
	logic          nfull_r, nfull_nxt, nempty_r, nempty_nxt;
	logic          wr, rd;
	assign o_in_ready  = nfull_r;
	assign o_out_valid = nempty_r;
	assign o_out_data  = mem_r[rp_r];
	always_comb begin
		wr = i_in_valid && nfull_r;
		rd = i_out_ready && nempty_r;
		mem_nxt = mem_r;
		wp_nxt = wp_r;
		rp_nxt = rp_r;
		cnt_nxt = cnt_r;
		if (wr) begin
			mem_nxt[wp_r] = i_in_data;
			wp_nxt = PW'(wp_r + 1'b1);
		end
		if (rd) begin
			rp_nxt = PW'(rp_r + 1'b1);
		end
		if (wr && !rd) begin
			cnt_nxt = CW'(cnt_r + 1'b1);
		end else if (rd && !wr) begin
			cnt_nxt = CW'(cnt_r - 1'b1);
		end
		nfull_nxt = (cnt_nxt != CW'(DEPTH));
		nempty_nxt = (cnt_nxt != '0);
	end
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			mem_r <= '{default: '0};
			wp_r <= '0;
			rp_r <= '0;
			cnt_r <= '0;
			nfull_r <= 1'b1;
			nempty_r <= 1'b0;
		end else begin
			mem_r <= mem_nxt;
			wp_r <= wp_nxt;
			rp_r <= rp_nxt;
			cnt_r <= cnt_nxt;
			nfull_r <= nfull_nxt;
			nempty_r <= nempty_nxt;
		end
	end
	a_fifo_count: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		wr && !rd |=> cnt_r == $past(cnt_r) + 1'b1)
		else $error("fifo count did not grow on write");
endmodule : mif_fifo

// ===========================================================================
// filter core
module multibank_interp_fir #(
	parameter int NBANKS = `MIF_NBANKS,
	parameter int NTAPS  = `MIF_NTAPS,
	parameter int INTERP = `MIF_INTERP,
	parameter int NCH    = `MIF_NCH,
	parameter int DW     = `MIF_DW,
	parameter int CW     = `MIF_CW,
	parameter int ADDR_W = `MIF_ADDR_W,
	parameter int BS_W   = (NBANKS > 1) ? $clog2(NBANKS) : 1,
	parameter int CH_W   = (NCH > 1) ? $clog2(NCH) : 1,
	parameter int PH_W   = (INTERP > 1) ? $clog2(INTERP) : 1
) (
	input  wire logic              I_CORE_CLK,
	input  wire logic              I_RST_N,
	input  wire logic              I_IN_VALID,
	input  wire logic [DW-1:0]     I_IN_DATA,
	input  wire logic [CH_W-1:0]   I_IN_CHAN,
	output var  logic              O_IN_READY,
	input  wire logic [BS_W-1:0]   I_BANK_SEL,
	output var  logic              O_VALID,
	output var  logic [DW-1:0]     O_DATA,
	output var  logic [CH_W-1:0]   O_CHAN,
	output var  logic [PH_W-1:0]   O_PHASE,
	output var  logic [BS_W-1:0]   O_BANK,
	input  wire logic              I_OUT_READY,
	input  wire logic              I_COEF_WE,
	input  wire logic [ADDR_W-1:0] I_COEF_ADDR,
	input  wire logic [CW-1:0]     I_COEF_DATA
);
	localparam int TPP   = NTAPS / INTERP;
	localparam int NCOEF = NBANKS * NTAPS;
	localparam int CI_W  = $clog2(NCOEF);
	localparam int ACC_W = DW + CW + $clog2(TPP) + 1;
	// ========================================================================
	// coefficient addressing
	function automatic logic [CI_W-1:0] coef_idx(input logic [BS_W-1:0] b, input int t);
		int v;
		v = int'(b) * NTAPS + t;
		return CI_W'(v);
	endfunction : coef_idx
	multibank_interp_fir_pkg::fsm_t state_r, state_nxt;
	logic signed [CW-1:0] coef_r   [NCOEF];
	logic signed [CW-1:0] coef_nxt [NCOEF];
	logic signed [DW-1:0] dl_r     [NCH][TPP];
	logic signed [DW-1:0] dl_nxt   [NCH][TPP];
	logic [PH_W-1:0]      phase_r, phase_nxt;
	logic [BS_W-1:0]      bank_r, bank_nxt, sel_eff;
	logic [CH_W-1:0]      ch_r, ch_nxt, f_ch;
	logic                 ov_r, ov_nxt;
	logic [DW-1:0]        od_r, od_nxt, f_data;
	logic [CH_W-1:0]      oc_r, oc_nxt;
	logic [PH_W-1:0]      op_r, op_nxt;
	logic                 f_valid, f_ready, pop, out_free, coef_hit;
	logic [ADDR_W-1:0]    coef_off;
	logic signed [ACC_W-1:0] acc;

	// ========================================================================
	// input fifo, stalled while phases are produced
	mif_fifo #(.W(CH_W + DW), .DEPTH(`MIF_FIFO_DEPTH)) u_fifo (
		.i_clk       (I_CORE_CLK),
		.i_rst_n     (I_RST_N),
		.i_in_valid  (I_IN_VALID),
		.i_in_data   ({I_IN_CHAN, I_IN_DATA}),
		.o_in_ready  (O_IN_READY),
		.o_out_valid (f_valid),
		.o_out_data  ({f_ch, f_data}),
		.i_out_ready (f_ready)
	);
	assign f_ready  = (state_r == multibank_interp_fir_pkg::ST_IDLE);
	assign pop      = f_ready && f_valid;
	assign out_free = !ov_r || I_OUT_READY;
	assign O_VALID  = ov_r;
	assign O_DATA   = od_r;
	assign O_CHAN   = oc_r;
	assign O_PHASE  = op_r;
	assign O_BANK   = bank_r;
	// out-of-range selects clamp to the last bank rather than read garbage
	always_comb begin
		sel_eff = '0;
		if (NBANKS > 1) begin
			sel_eff = (int'(I_BANK_SEL) >= NBANKS) ? BS_W'(NBANKS - 1) : I_BANK_SEL;
		end
	end
	// one polyphase branch per cycle, all taps of it in parallel
	always_comb begin
		acc = '0;
		for (int j = 0; j < TPP; j++) begin
			acc = acc + ACC_W'(coef_r[coef_idx(bank_r, int'(phase_r) + INTERP * j)]
				* dl_r[ch_r][j]);
		end
	end
	// the host offset is unchecked against the active bank; keeping it off is its duty
	always_comb begin
		coef_off = ADDR_W'(I_COEF_ADDR - `MIF_COEF_BASE);
		coef_hit = I_COEF_WE && (I_COEF_ADDR >= `MIF_COEF_BASE)
			&& (int'(coef_off) < NCOEF);
	end

	// ========================================================================
	// sequencing
	always_comb begin
		state_nxt = state_r;
		phase_nxt = phase_r;
		bank_nxt = bank_r;
		ch_nxt = ch_r;
		ov_nxt = ov_r;
		od_nxt = od_r;
		oc_nxt = oc_r;
		op_nxt = op_r;
		dl_nxt = dl_r;
		coef_nxt = coef_r;
		if (ov_r && I_OUT_READY) begin
			ov_nxt = 1'b0;
		end
		case (state_r)
			multibank_interp_fir_pkg::ST_IDLE: begin
				if (f_valid) begin
					ch_nxt = f_ch;
					bank_nxt = sel_eff;
					phase_nxt = '0;
					for (int j = TPP - 1; j > 0; j--) begin
						dl_nxt[f_ch][j] = dl_r[f_ch][j-1];
					end
					dl_nxt[f_ch][0] = f_data;
					state_nxt = multibank_interp_fir_pkg::ST_CALC;
				end
			end
			multibank_interp_fir_pkg::ST_CALC: begin
				if (out_free) begin
					ov_nxt = 1'b1;
					od_nxt = acc[CW-1 +: DW];
					oc_nxt = ch_r;
					op_nxt = phase_r;
					if (phase_r == PH_W'(INTERP - 1)) begin
						state_nxt = multibank_interp_fir_pkg::ST_IDLE;
					end else begin
						phase_nxt = PH_W'(phase_r + 1'b1);
					end
				end
			end
			default: begin
				state_nxt = multibank_interp_fir_pkg::ST_IDLE;
			end
		endcase
		if (coef_hit) begin
			coef_nxt[CI_W'(coef_off)] = I_COEF_DATA;
		end
	end
	always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			state_r <= multibank_interp_fir_pkg::ST_IDLE;
			coef_r <= '{default: `MIF_COEF_RST};
			dl_r <= '{default: '0};
			phase_r <= '0;
			bank_r <= '0;
			ch_r <= '0;
			ov_r <= 1'b0;
			od_r <= '0;
			oc_r <= '0;
			op_r <= '0;
		end else begin
			state_r <= state_nxt;
			coef_r <= coef_nxt;
			dl_r <= dl_nxt;
			phase_r <= phase_nxt;
			bank_r <= bank_nxt;
			ch_r <= ch_nxt;
			ov_r <= ov_nxt;
			od_r <= od_nxt;
			oc_r <= oc_nxt;
			op_r <= op_nxt;
		end
	end
	// ========================================================================
	// checks
	default clocking cb @(posedge I_CORE_CLK); endclocking
	default disable iff (!I_RST_N);
	sequence s_pop;
		pop ##1 (state_r == multibank_interp_fir_pkg::ST_CALC);
	endsequence
	sequence s_last_phase;
		(state_r == multibank_interp_fir_pkg::ST_CALC) && out_free
			&& (phase_r == PH_W'(INTERP - 1));
	endsequence
	a_pop_bank_latch: assert property (pop |=> bank_r == $past(sel_eff))
		else $error("bank not latched on sample take");
	a_pop_enters_calc: assert property (pop |-> s_pop)
		else $error("sample take did not start phases");
	a_pop_shift_in: assert property (pop |=> dl_r[ch_r][0] == $past(f_data))
		else $error("sample not stored at head of line");
	a_last_to_idle: assert property (s_last_phase
		|=> state_r == multibank_interp_fir_pkg::ST_IDLE)
		else $error("filter did not return idle after last phase");
	a_phase_out: assert property ((state_r == multibank_interp_fir_pkg::ST_CALC)
		&& out_free |=> O_VALID && O_PHASE == $past(phase_r) && O_CHAN == $past(ch_r))
		else $error("phase output missing");
	a_out_hold: assert property (O_VALID && !I_OUT_READY
		|=> O_VALID && $stable(O_DATA) && $stable(O_PHASE))
		else $error("output changed while stalled");
	a_bank_stable: assert property ((state_r == multibank_interp_fir_pkg::ST_CALC)
		|=> $stable(bank_r))
		else $error("bank changed within one sample");
	a_coef_write: assert property (coef_hit
		|=> coef_r[CI_W'($past(coef_off))] == $past(I_COEF_DATA))
		else $error("coefficient write lost");
	a_bank_decode: assert property (pop && (int'(I_BANK_SEL) < NBANKS)
		|=> bank_r == $past(I_BANK_SEL))
		else $error("bank select not taken as unsigned");
endmodule : multibank_interp_fir
`default_nettype wire

// *** multibank_interp_fir_cfg.svh ***
// constants of the multibank interpolating fir filter
`ifndef MULTIBANK_INTERP_FIR_CFG_SVH
`define MULTIBANK_INTERP_FIR_CFG_SVH
`define MIF_NBANKS      2
`define MIF_NTAPS       8
`define MIF_INTERP      2
`define MIF_NCH         4
`define MIF_DW          16
`define MIF_CW          16
`define MIF_ADDR_W      16
`define MIF_FIFO_DEPTH  8
`define MIF_COEF_BASE   16'h0000
`define MIF_COEF_RST    16'h0000
`endif

// *** multibank_interp_fir_pkg.sv ***
// types of the multibank interpolating fir filter
package multibank_interp_fir_pkg;
	typedef enum logic [0:0] {ST_IDLE, ST_CALC} fsm_t;
endpackage : multibank_interp_fir_pkg

// *** tb_multibank_interp_fir.sv ***
// testbench of the multibank interpolating fir filter
`include "multibank_interp_fir_cfg.svh"
`timescale 1ns/100ps
`default_nettype none

// ===========================================================================
// top
module tb_multibank_interp_fir;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        in_valid = 1'b0;
	logic [15:0] in_data = 16'h0000;
	logic [1:0]  in_chan = 2'h0;
	logic        in_ready;
	logic [0:0]  bank_sel = 1'h0;
	logic        o_valid;
	logic [15:0] o_data;
	logic [0:0]  o_bank;
	logic        out_ready;
	logic        coef_we = 1'b0;
	logic [15:0] coef_addr = 16'h0000;
	logic [15:0] coef_data = 16'h0000;
	logic        stall = 1'b0;
	logic        slow = 1'b0;
	logic [15:0] cnt;
	logic [15:0] s_data;
	logic [0:0]  s_bank;
	logic [1:0]  o_chan;
	logic [0:0]  o_phase;
	logic [1:0]  s_chan;
	logic [0:0]  s_phase;
	int          n_mismatch = 0;
	int          num_checks = 0;
	int          cycles = 0;

	always #12.5 clk = ~clk;

	multibank_interp_fir i_dut (.I_CORE_CLK(clk), .I_RST_N(rst_n), .I_IN_VALID(in_valid),
		.I_IN_DATA(in_data), .I_IN_CHAN(in_chan), .O_IN_READY(in_ready),
		.I_BANK_SEL(bank_sel), .O_VALID(o_valid), .O_DATA(o_data), .O_CHAN(o_chan),
		.O_PHASE(o_phase), .O_BANK(o_bank), .I_OUT_READY(out_ready), .I_COEF_WE(coef_we),
		.I_COEF_ADDR(coef_addr), .I_COEF_DATA(coef_data));

	mif_sink_model i_sink (.i_clk(clk), .i_rst_n(rst_n), .i_stall(stall), .i_slow(slow),
		.i_valid(o_valid), .i_data(o_data), .i_bank(o_bank), .i_chan(o_chan),
		.i_phase(o_phase), .o_ready(out_ready), .o_count(cnt), .o_data(s_data),
		.o_bank(s_bank), .o_chan(s_chan), .o_phase(s_phase));

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : wrap_up

	always @(posedge clk) begin
		cycles++;
		// ceiling well above the hundred or so cycles the scenarios need
		if (cycles == 5000) begin
			n_mismatch++;
			wrap_up();
		end
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		coef_we   <= 1'b1;
		coef_addr <= a;
		coef_data <= d;
		@(posedge clk);
	endtask : wr

	// holds the sample until the edge that takes it
	task automatic push(input logic [1:0] ch, input logic [15:0] x);
		in_valid <= 1'b1;
		in_chan  <= ch;
		in_data  <= x;
		do @(posedge clk); while (in_ready !== 1'b1);
		in_valid <= 1'b0;
	endtask : push

	task automatic wait_cnt(input logic [15:0] n);
		for (int i = 0; i < 400 && cnt < n; i++) @(posedge clk);
	endtask : wait_cnt

	task automatic t_reset;
		chk({15'h0, in_ready}, 16'h0001);
		chk({15'h0, o_valid}, 16'h0000);
		chk({15'h0, o_bank}, 16'h0000);
	endtask : t_reset

	task automatic t_banks;
		// bank 1 idle while bank 0 stays selected; out-of-range word must vanish
		wr(16'h0008, 16'h4000);
		wr(16'h0009, 16'h2000);
		wr(16'h000b, 16'h1000);
		// one past the last bank; a cut address would land on bank 0 tap 1
		wr(16'h0011, 16'h7fff);
		coef_we <= 1'b0;
		push(2'h1, 16'h0100);
		wait_cnt(16'h0002);
		chk(s_data, 16'h0000);
		bank_sel <= 1'h1;
		push(2'h2, 16'h0100);
		wait_cnt(16'h0004);
		chk(s_data, 16'h0040);
		chk({15'h0, s_bank}, 16'h0001);
		chk({14'h0, s_chan}, 16'h0002);
		chk({15'h0, s_phase}, 16'h0001);
	endtask : t_banks

	task automatic t_fill;
		int          n;
		logic [15:0] c0;
		n  = 0;
		c0 = cnt;
		stall    <= 1'b1;
		in_valid <= 1'b1;
		in_chan  <= 2'h3;
		in_data  <= 16'h0100;
		repeat (12) begin
			@(posedge clk);
			if (in_ready === 1'b1)
				n++;
		end
		in_valid <= 1'b0;
		chk({15'h0, in_ready}, 16'h0000);
		stall <= 1'b0;
		slow  <= 1'b1;
		wait_cnt(c0 + 16'(2 * n));
		repeat (8) @(posedge clk);
		chk(cnt, c0 + 16'(2 * n));
		chk({15'h0, s_bank}, 16'h0001);
		chk(s_data, 16'h0060);
		chk({14'h0, s_chan}, 16'h0003);
		chk({15'h0, s_phase}, 16'h0001);
	endtask : t_fill

	initial begin
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		t_reset();
		t_banks();
		t_fill();
		wrap_up();
	end
endmodule : tb_multibank_interp_fir

`default_nettype wire
